// ===== inc/pcfg_pkg.sv
package pcfg_pkg;

  // Word indices of the implemented header words
  localparam logic [5:0] PCFG_IDX_IDENT = 6'h00;
  localparam logic [5:0] PCFG_IDX_CMDSTAT = 6'h01;
  localparam logic [5:0] PCFG_IDX_CLASSREV = 6'h02;
  localparam logic [7:0] PCFG_OFS_CMDSTAT = 8'h04;

  // Command/status word after hardware reset
  localparam logic [31:0] PCFG_CMDSTAT_RESET = 32'h02900000;
  localparam logic [15:0] PCFG_CMD_RESET = 16'h0000;
  localparam logic [15:0] PCFG_CMD_WR_MASK = 16'h0147;

  // Command bit positions
  localparam int PCFG_CMD_IO_POS = 0;
  localparam int PCFG_CMD_MEM_POS = 1;
  localparam int PCFG_CMD_MASTER_POS = 2;
  localparam int PCFG_CMD_PARITY_POS = 6;
  localparam int PCFG_CMD_SERR_POS = 8;

  // Status bit positions in the whole word
  localparam int PCFG_ST_PARITY_SEEN_POS = 31;
  localparam int PCFG_ST_SERR_POS = 30;
  localparam int PCFG_ST_MABORT_POS = 29;
  localparam int PCFG_ST_TABORT_RX_POS = 28;
  localparam int PCFG_ST_TABORT_TX_POS = 27;
  localparam int PCFG_ST_SPEED_LSB = 25;
  localparam int PCFG_ST_MPAR_POS = 24;
  localparam int PCFG_ST_B2B_POS = 23;
  localparam int PCFG_ST_CAP_POS = 20;

  localparam logic [1:0] PCFG_SELECT_SPEED_MEDIUM = 2'h1;
  localparam logic PCFG_B2B_CAPABLE = 1'b1;
  localparam logic PCFG_CAP_RESET = 1'b1;

  // Class/revision constant fields
  localparam logic [7:0] PCFG_BASE_CLASS = 8'h02;
  localparam logic [7:0] PCFG_SUBCLASS = 8'h00;
  localparam logic [7:0] PCFG_PROG_IF = 8'h00;

  // Loaded identity fields before the serial loader finishes
  localparam logic [15:0] PCFG_ID_RESET = 16'h0000;
  localparam logic [7:0] PCFG_REV_RESET = 8'h00;

  localparam int PCFG_NFLAGS = 6;
  localparam logic [PCFG_NFLAGS-1:0] PCFG_FLAGS_RESET = 6'h00;

  // Sticky flag order inside the flag vector
  localparam int PCFG_F_MPAR = 0;
  localparam int PCFG_F_TABORT_TX = 1;
  localparam int PCFG_F_TABORT_RX = 2;
  localparam int PCFG_F_MABORT = 3;
  localparam int PCFG_F_SERR = 4;
  localparam int PCFG_F_PARITY_SEEN = 5;

  typedef struct packed {
    logic write;
    logic burst;
    logic [5:0] index;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcfg_req_t;

  typedef struct packed {
    logic parity_error;
    logic address_parity_error;
    logic master_data_parity;
    logic master_abort;
    logic target_abort_rcvd;
    logic target_abort_sent;
  } pcfg_evt_t;

  typedef struct packed {
    logic [15:0] device_identifier;
    logic [15:0] vendor_identifier;
    logic [7:0] revision;
  } pcfg_ee_t;

  typedef struct packed {
    logic io_window_respond;
    logic memory_window_respond;
    logic master_capability_enable;
    logic parity_response_enable;
    logic system_fault_report_enable;
    logic isolated;
    logic [1:0] target_select_speed;
  } pcfg_ctl_t;

  function automatic logic [31:0] pcfg_be_mask(input logic [3:0] be);
    pcfg_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : pcfg_be_mask

endpackage : pcfg_pkg

// ===== hw/pcfg_status_flags.sv
module pcfg_status_flags
  import pcfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [PCFG_NFLAGS-1:0] set_flags,
  input wire logic [PCFG_NFLAGS-1:0] clear_flags,
  output logic [PCFG_NFLAGS-1:0] flags
);

  logic [PCFG_NFLAGS-1:0] flags_ff;
  logic [PCFG_NFLAGS-1:0] nxt_flags;

  // Set beats a clear landing in the same cycle
  always_comb begin
    nxt_flags = (flags_ff & ~clear_flags) | set_flags;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= PCFG_FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

endmodule : pcfg_status_flags

// ===== hw/pcfg_header.sv
// How it works
// - Identification upper half holds device identifier, loaded from serial memory after reset.
// - Identification lower half holds vendor identifier, loaded from serial memory after reset.
// - Command/status word reads its fixed reset value after hardware reset, except bit 20, which then takes the strap.
// - All-zero command isolates device from all but configuration access, no mastering.
// - Writing one clears a status bit; writing zero leaves it alone.
// - Bit 31 sets on any detected parity error, regardless of parity response.
// - Bit 30 sets whenever the device drives the system error pin.
// - Bit 29 sets when an own master transaction ends in master abort.
// - Bit 28 sets when a target aborts an own master transaction.
// - Bit 27 sets when the device as target ends with target abort.
// - Bits 26:25 read 01, medium select timing, given to target logic.
// - Bit 24 sets only on own master parity error with parity response on.
// - Bit 23 reads constant one, back-to-back capable.
// - Bit 20 follows power management strap sampled at hardware reset release.
// - System error on address parity error only when bits 8 and 6 set.
// - With bit 6 clear, parity errors do not change response behaviour.
// - Parity checking and generation stay on whatever bit 6 says.
// - Mastering allowed only while command bit 2 is set.
// - Memory claimed only with bit 1, I/O only with bit 0.
// - Reserved command/status positions always read zero.
// - Class word returns base class 02h, subclass 00h, interface zero.
// - Revision byte is read-only, loaded from serial memory after reset.
// - Software reset leaves all configuration words untouched.
// - Every byte enable combination honoured; only enabled bytes written.
// - Burst configuration access disconnected after its first data phase.
module pcfg_header
  import pcfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cfg_valid,
  input wire pcfg_req_t cfg_req,
  output logic cfg_ack,
  output logic cfg_disconnect,
  output logic [31:0] cfg_rdata,
  input wire logic ee_load_valid,
  input wire pcfg_ee_t ee_load_data,
  input wire logic power_mgmt_strap,
  input wire pcfg_evt_t bus_events,
  output pcfg_ctl_t control,
  output logic system_error_pin_o,
  output logic system_error_pin_oe_n,
  output logic [31:0] identification_word,
  output logic [31:0] command_status_word,
  output logic [31:0] class_revision_word
);

  // Reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync_ff;

  // Strap capture at release; only hardware reset restarts it
  logic strap_taken_ff;
  logic nxt_strap_taken;
  logic cap_present_ff;
  logic nxt_cap_present;

  always_comb begin
    nxt_strap_taken = 1'b1;
    nxt_cap_present = cap_present_ff;
    if (!strap_taken_ff) begin
      nxt_cap_present = power_mgmt_strap;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken_ff <= 1'b0;
      cap_present_ff <= PCFG_CAP_RESET;
    end else begin
      strap_taken_ff <= nxt_strap_taken;
      cap_present_ff <= nxt_cap_present;
    end
  end

  // Identity fields from the serial loader
  logic [15:0] device_identifier_ff;
  logic [15:0] vendor_identifier_ff;
  logic [7:0] revision_ff;
  logic [15:0] nxt_device_identifier;
  logic [15:0] nxt_vendor_identifier;
  logic [7:0] nxt_revision;

  always_comb begin
    nxt_device_identifier = device_identifier_ff;
    nxt_vendor_identifier = vendor_identifier_ff;
    nxt_revision = revision_ff;
    if (ee_load_valid) begin
      nxt_device_identifier = ee_load_data.device_identifier;
      nxt_vendor_identifier = ee_load_data.vendor_identifier;
      nxt_revision = ee_load_data.revision;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      device_identifier_ff <= PCFG_ID_RESET;
      vendor_identifier_ff <= PCFG_ID_RESET;
      revision_ff <= PCFG_REV_RESET;
    end else begin
      device_identifier_ff <= nxt_device_identifier;
      vendor_identifier_ff <= nxt_vendor_identifier;
      revision_ff <= nxt_revision;
    end
  end

  // Access handshake
  logic take;
  logic busy_ff;
  logic nxt_busy;
  logic ack_ff;
  logic nxt_ack;
  logic disc_ff;
  logic nxt_disc;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] wmask;
  logic wr_cmdstat;

  // At most one take every other cycle
  assign take = cfg_valid && !busy_ff;
  assign wmask = pcfg_be_mask(cfg_req.be);
  assign wr_cmdstat = take && cfg_req.write && (cfg_req.index == PCFG_IDX_CMDSTAT);

  // Old value outside the enabled writable lanes, new value inside
  function automatic logic [15:0] merge_lanes(
    input logic [15:0] old_value,
    input logic [15:0] new_value,
    input logic [15:0] lanes
  );
    merge_lanes = (old_value & ~lanes) | (new_value & lanes);
  endfunction : merge_lanes

  // Command half
  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;

  always_comb begin
    nxt_cmd = cmd_ff;
    if (wr_cmdstat) begin
      // Read-only and reserved bits keep their value
      nxt_cmd = merge_lanes(cmd_ff, cfg_req.wdata[15:0], wmask[15:0] & PCFG_CMD_WR_MASK);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= PCFG_CMD_RESET;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  logic par_resp;
  logic serr_en;
  assign par_resp = cmd_ff[PCFG_CMD_PARITY_POS];
  assign serr_en = cmd_ff[PCFG_CMD_SERR_POS];

  // System error drive, one cycle per address parity error while command bits 8 and 6 are set
  logic serr_drive_ff;
  logic nxt_serr_drive;

  always_comb begin
    nxt_serr_drive = bus_events.address_parity_error && serr_en && par_resp;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serr_drive_ff <= 1'b0;
    end else begin
      serr_drive_ff <= nxt_serr_drive;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign system_error_pin_o = 1'b0;
  assign system_error_pin_oe_n = !serr_drive_ff;

  // Sticky status events
  logic [PCFG_NFLAGS-1:0] set_flags;
  logic [PCFG_NFLAGS-1:0] clear_flags;
  logic [PCFG_NFLAGS-1:0] flags;
  logic [31:0] clr_word;

  assign clr_word = wr_cmdstat ? (cfg_req.wdata & wmask) : 32'h00000000;

  always_comb begin
    set_flags = '0;
    set_flags[PCFG_F_PARITY_SEEN] = bus_events.parity_error
                                  || bus_events.address_parity_error;
    set_flags[PCFG_F_SERR] = serr_drive_ff;
    set_flags[PCFG_F_MABORT] = bus_events.master_abort;
    set_flags[PCFG_F_TABORT_RX] = bus_events.target_abort_rcvd;
    set_flags[PCFG_F_TABORT_TX] = bus_events.target_abort_sent;
    set_flags[PCFG_F_MPAR] = bus_events.master_data_parity && par_resp;
    clear_flags = '0;
    clear_flags[PCFG_F_PARITY_SEEN] = clr_word[PCFG_ST_PARITY_SEEN_POS];
    clear_flags[PCFG_F_SERR] = clr_word[PCFG_ST_SERR_POS];
    clear_flags[PCFG_F_MABORT] = clr_word[PCFG_ST_MABORT_POS];
    clear_flags[PCFG_F_TABORT_RX] = clr_word[PCFG_ST_TABORT_RX_POS];
    clear_flags[PCFG_F_TABORT_TX] = clr_word[PCFG_ST_TABORT_TX_POS];
    clear_flags[PCFG_F_MPAR] = clr_word[PCFG_ST_MPAR_POS];
  end

  pcfg_status_flags u_flags (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_flags(set_flags),
    .clear_flags(clear_flags),
    .flags(flags)
  );

  // Assembled words
  logic [31:0] cs_word;

  always_comb begin
    cs_word = 32'h00000000;
    cs_word[15:0] = cmd_ff;
    cs_word[PCFG_ST_PARITY_SEEN_POS] = flags[PCFG_F_PARITY_SEEN];
    cs_word[PCFG_ST_SERR_POS] = flags[PCFG_F_SERR];
    cs_word[PCFG_ST_MABORT_POS] = flags[PCFG_F_MABORT];
    cs_word[PCFG_ST_TABORT_RX_POS] = flags[PCFG_F_TABORT_RX];
    cs_word[PCFG_ST_TABORT_TX_POS] = flags[PCFG_F_TABORT_TX];
    cs_word[PCFG_ST_SPEED_LSB +: 2] = PCFG_SELECT_SPEED_MEDIUM;
    cs_word[PCFG_ST_MPAR_POS] = flags[PCFG_F_MPAR];
    cs_word[PCFG_ST_B2B_POS] = PCFG_B2B_CAPABLE;
    cs_word[PCFG_ST_CAP_POS] = cap_present_ff;
  end

  assign command_status_word = cs_word;
  assign identification_word = {device_identifier_ff, vendor_identifier_ff};
  assign class_revision_word = {PCFG_BASE_CLASS, PCFG_SUBCLASS, PCFG_PROG_IF, revision_ff};

  // Word selected by a read; unmapped indices read zero
  function automatic logic [31:0] pick_word(
    input logic [5:0] index,
    input logic [31:0] ident,
    input logic [31:0] cmdstat,
    input logic [31:0] classrev
  );
    case (index)
      PCFG_IDX_IDENT: pick_word = ident;
      PCFG_IDX_CMDSTAT: pick_word = cmdstat;
      PCFG_IDX_CLASSREV: pick_word = classrev;
      default: pick_word = 32'h00000000;
    endcase
  endfunction : pick_word

  // Read path and termination
  always_comb begin
    nxt_ack = take;
    nxt_busy = take;
    nxt_disc = take && cfg_req.burst;
    nxt_rdata = rdata_ff;
    if (take && !cfg_req.write) begin
      nxt_rdata = pick_word(cfg_req.index, identification_word, cs_word, class_revision_word) & wmask;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      ack_ff <= 1'b0;
      disc_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      busy_ff <= nxt_busy;
      ack_ff <= nxt_ack;
      disc_ff <= nxt_disc;
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_ack = ack_ff;
  assign cfg_disconnect = disc_ff;
  assign cfg_rdata = rdata_ff;

  // Enables toward target and master logic
  always_comb begin
    control.io_window_respond = cmd_ff[PCFG_CMD_IO_POS];
    control.memory_window_respond = cmd_ff[PCFG_CMD_MEM_POS];
    control.master_capability_enable = cmd_ff[PCFG_CMD_MASTER_POS];
    control.parity_response_enable = par_resp;
    control.system_fault_report_enable = serr_en;
    control.isolated = (cmd_ff == PCFG_CMD_RESET);
    control.target_select_speed = PCFG_SELECT_SPEED_MEDIUM;
  end

endmodule : pcfg_header

// ===== verif/pcfg_header_assertions.sv
module pcfg_header_assertions
  import pcfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cfg_valid,
  input wire pcfg_req_t cfg_req,
  input wire logic cfg_ack,
  input wire logic cfg_disconnect,
  input wire logic [31:0] cfg_rdata,
  input wire logic ee_load_valid,
  input wire pcfg_ee_t ee_load_data,
  input wire logic power_mgmt_strap,
  input wire pcfg_evt_t bus_events,
  input wire pcfg_ctl_t control,
  input wire logic system_error_pin_o,
  input wire logic system_error_pin_oe_n,
  input wire logic [31:0] identification_word,
  input wire logic [31:0] command_status_word,
  input wire logic [31:0] class_revision_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  resv_zero_a: assert property ((command_status_word & 32'h006ffeb8) == 32'h0) else $error("reserved bit set");
  b2b_fixed_a: assert property (command_status_word[23]) else $error("b2b bit low");
  speed_fixed_a: assert property (command_status_word[26:25] == 2'h1) else $error("speed field wrong");
  class_fixed_a: assert property (class_revision_word[31:8] == 24'h020000) else $error("class wrong");
  isolate_ctl_a: assert property (control.isolated == (command_status_word[15:0] == 16'h0)) else $error("isolate");
  window_ctl_a: assert property ({control.master_capability_enable, control.memory_window_respond,
    control.io_window_respond} == command_status_word[2:0]) else $error("enables differ");
  serr_cause_a: assert property (!system_error_pin_oe_n |-> $past(bus_events.address_parity_error)
    && $past(command_status_word[8]) && $past(command_status_word[6])) else $error("serr without cause");
  serr_flag_a: assert property (!system_error_pin_oe_n |=> command_status_word[30]) else $error("serr flag");
  parity_seen_a: assert property (bus_events.parity_error |-> ##1 command_status_word[31]) else $error("par");
  mpar_gate_a: assert property ($rose(command_status_word[24]) |-> $past(bus_events.master_data_parity)
    && $past(command_status_word[6])) else $error("mpar set without cause");
  ident_ro_a: assert property ($changed(identification_word) |->
    $past(ee_load_valid) || $past(ee_load_valid, 2)) else $error("ident changed");
  rev_ro_a: assert property ($changed(class_revision_word[7:0]) |->
    $past(ee_load_valid) || $past(ee_load_valid, 2)) else $error("rev changed");
  burst_disc_a: assert property (cfg_disconnect |-> cfg_ack && $past(cfg_req.burst)) else $error("disc");
endmodule : pcfg_header_assertions

bind pcfg_header pcfg_header_assertions chk (.sys_clk, .resetn, .cfg_valid, .cfg_req, .cfg_ack,
  .cfg_disconnect, .cfg_rdata, .ee_load_valid, .ee_load_data, .power_mgmt_strap, .bus_events, .control,
  .system_error_pin_o, .system_error_pin_oe_n, .identification_word, .command_status_word, .class_revision_word);

// ===== verif/pcfg_host_model.sv
module pcfg_host_model
  import pcfg_pkg::*;
(
  input wire logic sys_clk,
  output logic cfg_valid,
  output pcfg_req_t cfg_req,
  input wire logic cfg_ack,
  input wire logic cfg_disconnect,
  input wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cfg_valid = 1'b0;
    cfg_req = '0;
  end
  // Released request lines show the inverse so stale values never look valid
  task automatic access(input pcfg_req_t rq, input int idle, output logic [31:0] rd, output logic ak,
    output logic dc);
    repeat (idle) @(negedge sys_clk);
    @(negedge sys_clk);
    cfg_req = rq;
    cfg_valid = 1'b1;
    ak = 1'b0;
    // Hold until the edge that sees the ack; give up after four edges
    for (int n = 0; n < 4 && ak !== 1'b1; n++) begin
      @(posedge sys_clk);
      ak = cfg_ack;
    end
    rd = cfg_rdata;
    dc = cfg_disconnect;
    @(negedge sys_clk);
    cfg_valid = 1'b0;
    cfg_req = ~rq;
  endtask : access
endmodule : pcfg_host_model

// ===== verif/tb_pci_config_header_id_cmd_status.sv
module tb_pci_config_header_id_cmd_status;
  import pcfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_valid, cfg_ack, cfg_disconnect, system_error_pin_o, system_error_pin_oe_n;
  logic ee_load_valid = 1'b0;
  logic power_mgmt_strap = 1'b1;
  logic [31:0] cfg_rdata, identification_word, command_status_word, class_revision_word;
  pcfg_req_t cfg_req;
  pcfg_ee_t ee_load_data = '0;
  pcfg_evt_t bus_events = '0;
  pcfg_ctl_t control;
  int err_total = 0;
  int checks = 0;
  int cmd, st, id, rev, cap;
  int exp_q[$];
  logic [39:0] ee;
  logic [31:0] rd;
  logic [3:0] be;

  always #20 sys_clk = ~sys_clk;

  pcfg_header DUT (.sys_clk, .resetn, .cfg_valid, .cfg_req, .cfg_ack, .cfg_disconnect, .cfg_rdata,
    .ee_load_valid, .ee_load_data, .power_mgmt_strap, .bus_events, .control, .system_error_pin_o,
    .system_error_pin_oe_n, .identification_word, .command_status_word, .class_revision_word);
  pcfg_host_model host (.sys_clk, .cfg_valid, .cfg_req, .cfg_ack, .cfg_disconnect, .cfg_rdata);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] bmask(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction : bmask

  task automatic acc(input bit wr, input logic [5:0] ix, input logic [3:0] b, input logic [31:0] wd,
    output logic [31:0] r);
    logic ak, dc;
    bit bu;
    bu = 1'($urandom_range(1));
    host.access({wr, bu, ix, b, wd}, $urandom_range(2), r, ak, dc);
    chk({30'h0, ak, dc}, {30'h0, 1'b1, bu});
  endtask : acc

  task automatic wr_cs(input logic [3:0] b, input logic [31:0] wd);
    logic [31:0] m, r;
    m = bmask(b);
    cmd = (cmd & ~m) | (wd & m & 32'h147);
    st = st & ~(wd & m & 32'hf9000000);
    acc(1'b1, 6'h01, b, wd, r);
    be = 4'($urandom);
    acc(1'b0, 6'h01, be, 32'h0, r);
    exp_q.push_back((st & 32'hf9000000) | 32'h02800000 | (cap << 20) | (cmd & 32'h147));
    chk(command_status_word, exp_q[0]);
    chk(r, exp_q.pop_front() & bmask(be));
    chk(32'(control), 32'({cmd[0], cmd[1], cmd[2], cmd[6], cmd[8], cmd[15:0] == 0, 2'b01}));
  endtask : wr_cs

  task automatic evt(input logic [5:0] e);
    bit sr;
    sr = e[4] && cmd[8] && cmd[6];
    @(negedge sys_clk);
    bus_events = e;
    @(negedge sys_clk);
    bus_events = '0;
    chk(32'(system_error_pin_oe_n), 32'(!sr));
    chk(32'(system_error_pin_o), 32'h0);
    if (e[5] || e[4]) st[31] = 1'b1;
    if (sr) st[30] = 1'b1;
    if (e[3] && cmd[6]) st[24] = 1'b1;
    if (e[2]) st[29] = 1'b1;
    if (e[1]) st[28] = 1'b1;
    if (e[0]) st[27] = 1'b1;
  endtask : evt

  task automatic do_reset(input bit strap);
    @(negedge sys_clk);
    resetn = 1'b0;
    power_mgmt_strap = strap;
    repeat (12) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    cmd = 0;
    st = 0;
    id = 0;
    rev = 0;
    cap = strap;
    wr_cs(4'h0, 32'h0);
    acc(1'b0, 6'h00, 4'hf, 32'h0, rd);
    chk(rd, 32'h0);
    acc(1'b0, 6'h02, 4'hf, 32'h0, rd);
    chk(rd, 32'h02000000);
    $display("reset test done strap %0d", strap);
  endtask : do_reset

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

  initial begin
    void'($urandom(81722));
    do_reset(1'b1);
    ee = 40'({$urandom, $urandom});
    @(negedge sys_clk);
    ee_load_data = ee;
    ee_load_valid = 1'b1;
    @(negedge sys_clk);
    ee_load_valid = 1'b0;
    id = ee[39:8];
    rev = ee[7:0];
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 6'(i[0] ? 2 : 0), 4'hf, $urandom, rd);
      be = 4'($urandom);
      acc(1'b0, 6'h00, be, 32'h0, rd);
      chk(rd, id & bmask(be));
      chk(identification_word, id);
      be = 4'($urandom);
      acc(1'b0, 6'h02, be, 32'h0, rd);
      chk(rd, {24'h020000, rev[7:0]} & bmask(be));
      chk(class_revision_word, {24'h020000, rev[7:0]});
      acc(1'b1, 6'($urandom_range(63, 3)), 4'hf, $urandom, rd);
      acc(1'b0, 6'($urandom_range(63, 3)), 4'hf, 32'h0, rd);
      chk(rd, 32'h0);
    end
    $display("identity test done");
    for (int i = 0; i < 16; i++) begin
      wr_cs(4'($urandom), $urandom);
    end
    wr_cs(4'h3, 32'h0);
    $display("command test done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        wr_cs(4'h3, p ? 32'h147 : 32'h105);
        evt(6'(1 << i));
        wr_cs(4'h0, 32'h0);
        wr_cs(4'hc, 32'hffff0000);
      end
    end
    $display("event test done");
    do_reset(1'b0);
    give_verdict();
  end
endmodule : tb_pci_config_header_id_cmd_status
